// file: logic/uv_detect_consts.svh
// Notes on behaviour
// - enabled: compare supply, raise interrupt or reset
// - ten selectable levels, interrupt or reset choice
// - keeps working while chip is in stop
// - detector reset sets reset cause flag bit0
// - control register clears except on own reset
// - bit7 enables detection when set
// - bit1 selects interrupt (0) or reset (1)
// - bit0 read-only, shows below-level when enabled
// - bit4 value undefined, never relied upon
// - own reset keeps enable and mode bits
// - flag drives interrupt when enabled, mode 0
// - control register takes bit and byte writes
// - level register byte writes only, reset 00h
// - no reset when mode set above level
`ifndef UV_DETECT_CONSTS_SVH
`define UV_DETECT_CONSTS_SVH
`define UV_CTRL_ADDR 16'hffbe
`define UV_LEVEL_ADDR 16'hffbf
`define UV_EN_BIT 7
`define UV_MODE_BIT 1
`define UV_FLAG_BIT 0
`define UV_CTRL_RESET 8'h00
`define UV_LEVEL_RESET 8'h00
`define UV_LEVEL_MASK 8'h0f
`define UV_SETTLE_US 200
`define UV_CLK_MHZ 100
`define UV_SETTLE_CYC ((`UV_SETTLE_US * `UV_CLK_MHZ))
`endif

// file: logic/uv_detect_pkg.sv
package uv_detect_pkg;
    typedef struct packed {
        logic wr;
        logic bit_wr;
        logic [2:0] bit_sel;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cpu_req_t;
    typedef struct packed {
        logic enable;
        logic reset_mode;
    } uv_ctrl_t;
endpackage

// file: logic/level_sync.sv
module level_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic meta_r;
    logic meta_nxt;
    logic q_r;
    logic q_nxt;
    always_comb begin
        meta_nxt = d;
        q_nxt = meta_r;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= 1'b0;
            q_r <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end
    assign q = q_r;
endmodule

// file: logic/supply_undervoltage_detector.sv
`include "uv_detect_consts.svh"
module supply_undervoltage_detector (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic UV_OWN_RST,
    input wire logic STOP_MODE,
    input wire uv_detect_pkg::cpu_req_t CPU_REQ,
    input wire logic CPU_RD,
    input wire logic [15:0] CPU_RD_ADDR,
    output logic [7:0] CPU_RDATA,
    output logic CPU_RD_HIT,
    input wire logic COMP_BELOW,
    output logic [3:0] LEVEL_CODE,
    output logic COMP_ON,
    output logic UNDERVOLTAGE_IRQ,
    output logic UV_RESET_REQ,
    output logic UNDERVOLTAGE_RESET_CAUSE_FLAG
);
    import uv_detect_pkg::*;

    // stop mode deliberately unused: detection runs in every mode
    logic below_s;

    // decoded strobes and the control byte as software sees it
    logic wr_ctrl;
    logic wr_level;
    logic wr_bit;
    logic rd_ctrl;
    logic rd_level;
    logic [7:0] ctrl_view;
    logic [7:0] ctrl_wr;

    uv_ctrl_t ctrl_r;
    uv_ctrl_t ctrl_nxt;
    logic [7:0] level_r;
    logic [7:0] level_nxt;

    logic flag_r;
    logic flag_nxt;
    logic irq_r;
    logic irq_nxt;
    logic rreq_r;
    logic rreq_nxt;
    logic cause_r;
    logic cause_nxt;

    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic hit_r;
    logic hit_nxt;

    level_sync u_sync (
        .clk(CLK_SYS),
        .rst(RST),
        .d(COMP_BELOW),
        .q(below_s)
    );

    always_comb begin
        wr_ctrl = CPU_REQ.wr && (CPU_REQ.addr == `UV_CTRL_ADDR);
        wr_level = CPU_REQ.wr && (CPU_REQ.addr == `UV_LEVEL_ADDR);
        wr_bit = CPU_REQ.bit_wr;
    end

    always_comb begin
        rd_ctrl = CPU_RD && (CPU_RD_ADDR == `UV_CTRL_ADDR);
        rd_level = CPU_RD && (CPU_RD_ADDR == `UV_LEVEL_ADDR);
    end

    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[`UV_EN_BIT] = ctrl_r.enable;
        ctrl_view[`UV_MODE_BIT] = ctrl_r.reset_mode;
        ctrl_view[`UV_FLAG_BIT] = flag_r;
    end

    // a bit write merges into the current image, so untouched bits keep their value
    always_comb begin
        ctrl_wr = ctrl_view;
        if (wr_bit) begin
            ctrl_wr[CPU_REQ.bit_sel] = CPU_REQ.wdata[0];
        end else begin
            ctrl_wr = CPU_REQ.wdata;
        end
    end

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt.enable = ctrl_wr[`UV_EN_BIT];
            ctrl_nxt.reset_mode = ctrl_wr[`UV_MODE_BIT];
        end
    end

    // only the general reset clears these; the detector's own reset leaves them
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ctrl_r <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    always_comb begin
        level_nxt = level_r;
        // only whole-byte writes reach the level register
        if (wr_level && !wr_bit) begin
            level_nxt = CPU_REQ.wdata & `UV_LEVEL_MASK;
        end
        // the detector's own reset returns the level to its default
        if (UV_OWN_RST) begin
            level_nxt = `UV_LEVEL_RESET;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            level_r <= `UV_LEVEL_RESET;
        end else begin
            level_r <= level_nxt;
        end
    end

    always_comb begin
        flag_nxt = 1'b0;
        if (ctrl_r.enable) begin
            flag_nxt = below_s;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    always_comb begin
        irq_nxt = 1'b0;
        if (ctrl_r.enable && !ctrl_r.reset_mode) begin
            irq_nxt = flag_r;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    // reset only from a synchronised low reading, so mode set while above gives none
    always_comb begin
        rreq_nxt = 1'b0;
        if (ctrl_r.enable && ctrl_r.reset_mode) begin
            rreq_nxt = flag_r;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            rreq_r <= 1'b0;
        end else begin
            rreq_r <= rreq_nxt;
        end
    end

    // sticky until the general reset; one request cycle is enough to mark the cause
    always_comb begin
        cause_nxt = cause_r;
        if (rreq_r) begin
            cause_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            cause_r <= 1'b0;
        end else begin
            cause_r <= cause_nxt;
        end
    end

    always_comb begin
        hit_nxt = rd_ctrl | rd_level;
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            hit_r <= 1'b0;
        end else begin
            hit_r <= hit_nxt;
        end
    end

    // bit4 reads zero here; software must ignore it anyway
    always_comb begin
        rdata_nxt = 8'h00;
        if (rd_ctrl) begin
            rdata_nxt = ctrl_view;
        end else if (rd_level) begin
            rdata_nxt = level_r;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign CPU_RDATA = rdata_r;
    assign CPU_RD_HIT = hit_r;
    assign LEVEL_CODE = level_r[3:0];
    assign COMP_ON = ctrl_r.enable;
    assign UNDERVOLTAGE_IRQ = irq_r;
    assign UV_RESET_REQ = rreq_r;
    assign UNDERVOLTAGE_RESET_CAUSE_FLAG = cause_r;
endmodule

// file: bench/uv_detect_assertions.sv
module uv_detect_checker (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic UV_OWN_RST,
    input wire logic CPU_RD,
    input wire logic CPU_RD_HIT,
    input wire logic COMP_ON,
    input wire logic UNDERVOLTAGE_IRQ,
    input wire logic UV_RESET_REQ,
    input wire logic UNDERVOLTAGE_RESET_CAUSE_FLAG,
    input wire logic [15:0] CPU_RD_ADDR,
    input wire logic [7:0] CPU_RDATA
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    wire irq = UNDERVOLTAGE_IRQ;
    wire req = UV_RESET_REQ;
    wire cause = UNDERVOLTAGE_RESET_CAUSE_FLAG;
    wire a_ctl = CPU_RD_ADDR == 16'hffbe;
    wire a_lvl = CPU_RD_ADDR == 16'hffbf;
    mode_excl_a: assert property (!(irq && req))
        else $error("irq and reset request together");
    // the request registers one cycle behind the enable, so compare with its previous value
    irq_en_a: assert property (irq |-> $past(COMP_ON))
        else $error("irq while disabled");
    req_en_a: assert property (req |-> $past(COMP_ON))
        else $error("reset request while disabled");
    cause_set_a: assert property (req |=> cause)
        else $error("cause flag not set");
    cause_hold_a: assert property (cause |=> cause)
        else $error("cause flag lost");
    own_keep_a: assert property (UV_OWN_RST && COMP_ON |=> COMP_ON)
        else $error("enable lost on own reset");
    lvl_high_a: assert property (CPU_RD && a_lvl |=> CPU_RD_HIT && CPU_RDATA[7:4] == 4'h0)
        else $error("level upper bits not zero");
    ctl_zero_a: assert property (CPU_RD && a_ctl |=>
        CPU_RD_HIT && CPU_RDATA[6:5] == 2'h0 && CPU_RDATA[3:2] == 2'h0)
        else $error("control fixed bits not zero");
    unmapped_read_a: assert property (CPU_RD && !a_ctl && !a_lvl |=> !CPU_RD_HIT && CPU_RDATA == 8'h00)
        else $error("unmapped read answered");
    irq_c: cover property (irq);
    req_c: cover property (req);
    own_c: cover property (UV_OWN_RST && COMP_ON);
endmodule
bind supply_undervoltage_detector uv_detect_checker u_uv_detect_checker (.CLK_SYS, .RST, .UV_OWN_RST, .CPU_RD,
    .CPU_RD_HIT, .COMP_ON, .UNDERVOLTAGE_IRQ, .UV_RESET_REQ, .UNDERVOLTAGE_RESET_CAUSE_FLAG, .CPU_RD_ADDR, .CPU_RDATA);

// file: bench/tb_top.sv
`include "uv_detect_consts.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import uv_detect_pkg::*;
    logic clk = 1'b0, rst = 1'b1, own = 1'b0, stp = 1'b0, rd = 1'b0, below = 1'b0, hit, on, irq, rreq, cause;
    cpu_req_t req = '0;
    logic [15:0] ra = '0;
    logic [7:0] rdata, d;
    logic [3:0] lvl;
    int failures = 0, samples_checked = 0;
    supply_undervoltage_detector u_supply_undervoltage_detector (.CLK_SYS(clk), .RST(rst), .UV_OWN_RST(own),
        .STOP_MODE(stp), .CPU_REQ(req), .CPU_RD(rd), .CPU_RD_ADDR(ra), .CPU_RDATA(rdata), .CPU_RD_HIT(hit),
        .COMP_BELOW(below), .LEVEL_CODE(lvl), .COMP_ON(on), .UNDERVOLTAGE_IRQ(irq), .UV_RESET_REQ(rreq),
        .UNDERVOLTAGE_RESET_CAUSE_FLAG(cause));
    initial forever #5 clk = ~clk;
    function automatic logic [7:0] ctl(input logic en, md, fl);
        return {en, 5'h00, md, fl};
    endfunction
    task automatic chk(input logic [7:0] s, e);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // wr and rdc each let one edge pass at their end, so a following call never re-raises a strobe in the same step
    task automatic wr(input logic [15:0] a, input logic [7:0] v, input logic b, input logic [2:0] s);
        req = '{1'b1, b, s, a, v};
        @(negedge clk);
        req.wr = 1'b0;
        @(negedge clk);
    endtask
    // bit4 is masked off: its read value is not fixed
    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        rd = 1'b1;
        ra = a;
        @(negedge clk);
        rd = 1'b0;
        chk(rdata & 8'hef, e);
        @(negedge clk);
    endtask
    task automatic close_out;
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // two settle waits plus a generous margin for the short scenarios
    initial begin
        repeat (2 * `UV_SETTLE_CYC + 10000) @(negedge clk);
        failures++;
        close_out;
    end
    initial begin
        void'($urandom(32'h4b0f));
        repeat (10) @(negedge clk);
        rst = 1'b0;
        rdc(16'hffbe, 8'h00);
        rdc(16'hffbf, 8'h00);
        rdc(16'h1234, 8'h00);
        for (int i = 0; i < 10; i++) begin
            // software keeps to the ten legal codes; both ends first
            d = (i == 0) ? 8'h09 : (i == 1) ? 8'h00 : 8'($urandom % 10);
            wr(16'hffbf, d, 1'b0, 3'h0);
            rdc(16'hffbf, d);
            chk({4'h0, lvl}, d);
        end
        // a bit write that would flip bit0 of the level must be dropped
        wr(16'hffbf, {7'h00, ~d[0]}, 1'b1, 3'h0);
        rdc(16'hffbf, d);
        wr(16'hffbe, 8'h81, 1'b0, 3'h0);
        repeat (`UV_SETTLE_CYC) @(negedge clk);
        rdc(16'hffbe, ctl(1'b1, 1'b0, 1'b0));
        below = 1'b1;
        stp = 1'b1;
        repeat (6) @(negedge clk);
        chk({7'h00, irq}, 8'h01);
        rdc(16'hffbe, ctl(1'b1, 1'b0, 1'b1));
        wr(16'hffbe, 8'h00, 1'b1, 3'h7);
        repeat (5) @(negedge clk);
        chk({7'h00, irq}, 8'h00);
        rdc(16'hffbe, ctl(1'b0, 1'b0, 1'b0));
        below = 1'b0;
        wr(16'hffbe, 8'hff, 1'b0, 3'h0);
        repeat (`UV_SETTLE_CYC) @(negedge clk);
        chk({7'h00, rreq}, 8'h00);
        rdc(16'hffbe, ctl(1'b1, 1'b1, 1'b0));
        below = 1'b1;
        repeat (6) @(negedge clk);
        chk({7'h00, rreq}, 8'h01);
        chk({7'h00, cause}, 8'h01);
        own = 1'b1;
        repeat (2) @(negedge clk);
        below = 1'b0;
        own = 1'b0;
        repeat (5) @(negedge clk);
        chk({7'h00, rreq}, 8'h00);
        rdc(16'hffbe, ctl(1'b1, 1'b1, 1'b0));
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        chk({7'h00, cause}, 8'h00);
        rdc(16'hffbe, 8'h00);
        close_out;
    end
endmodule
